// ==== verification/rsh_ref_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Reference inputs with activity monitors
// ----------------------------------------
module rsh_ref_model (
  input wire logic i_clk,         // Monitor clock
  input wire logic [1:0] i_fail,  // Bench command: input is dead
  output logic [1:0] o_signal_loss // Loss level per input
);
  // Monitor flags a dead input one cycle after the edge
  always_ff @(posedge i_clk) begin
    o_signal_loss <= i_fail;
  end
endmodule : rsh_ref_model

// ==== verification/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic i_clk = 1'b0, i_srst = 1'b1, hen_n = 1'b0, src = 1'b1, pin = 1'b0, sbit = 1'b0;
  logic revertive_enable = 1'b0, prio = 1'b0, crs = 1'b0;
  logic [1:0] mode = 2'h3, fail = 2'h0, cis = 2'h0, loss;
  logic [7:0] start = 8'h03, reval = 8'h04;
  logic [17:0] div = 18'h00002;
  rsh_pkg::rsh_input_stat_t st;
  logic hn, sel, rnow, rstk, stored;
  int miscompares = 0, check_count = 0, n;
  rsh_ref_model u_ref (.i_clk(i_clk), .i_fail(fail), .o_signal_loss(loss));
  rsh_ref_select u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_holdover_enable_n(hen_n),
    .i_switch_mode_code(mode), .i_source_internal(src), .i_select_pin(pin),
    .i_select_bit(sbit), .i_signal_loss(loss), .i_holdoff_start_value(start),
    .i_holdoff_clock_divider(div), .i_revalidation_count(reval), .i_revertive_enable(revertive_enable),
    .i_priority_high_in1(prio), .i_clear_input_sticky(cis), .i_clear_reference_sticky(crs),
    .o_input_stat(st), .o_holdover_active_n(hn), .o_selected_input_status(sel),
    .o_reference_status_now(rnow), .o_reference_status_sticky(rstk),
    .o_use_stored_value(stored));
  // Clock, 100 MHz
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0b seen %0b", nm, exp, got);
    end
  endtask : chk
  task step(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : step
  // Bounded wait for holdover flag (w=0) or reference status (w=1)
  task wait_lvl(input int w, input logic lvl, input int bound);
    n = 0;
    while (((w == 0) ? hn : rnow) !== lvl) begin
      if (n == bound) begin
        chk("wait", lvl, ~lvl);
        print_verdict();
      end
      n++;
      step(1);
    end
  endtask : wait_lvl
  task drive_fail(input logic [1:0] f);
    @(posedge i_clk) fail <= f;
    #1;
  endtask : drive_fail
  task pulse_crs;
    @(posedge i_clk) crs <= 1'b1;
    @(posedge i_clk) crs <= 1'b0;
    step(2);
  endtask : pulse_crs
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    step(6);
    chk("ref sticky", 1'b1, rstk);
    chk("sel", 1'b0, sel);
    chk("holdover_n", 1'b1, hn);
    @(posedge i_clk) i_srst <= 1'b0;
    wait_lvl(1, 1'b1, 60);
    pulse_crs();
    chk("ref sticky set", 1'b1, rstk);
  endtask : t_reset
  task t_manual;
    @(posedge i_clk) sbit <= 1'b1;
    wait_lvl(0, 1'b0, 6);
    chk("sel new", 1'b1, sel);
    chk("stored", 1'b1, stored);
    n = 0;
    while (hn === 1'b0 && n < 40) begin
      n++;
      step(1);
    end
    chk("hold long", 1'b1, n >= 8);
    chk("hold end", 1'b1, hn);
  endtask : t_manual
  task t_auto_switch;
    @(posedge i_clk) hen_n <= 1'b1;
    wait_lvl(1, 1'b1, 60);
    drive_fail(2'h2);
    wait_lvl(0, 1'b0, 8);
    chk("ref now", 1'b0, rnow);
    chk("ref sticky", 1'b0, rstk);
    chk("sel kept", 1'b1, sel);
    chk("in sticky", 1'b1, st.sticky[1]);
    wait_lvl(0, 1'b1, 40);
    chk("sel other", 1'b0, sel);
    chk("ref ok", 1'b1, rnow);
    @(posedge i_clk) cis <= 2'h2;
    @(posedge i_clk) cis <= 2'h0;
    step(2);
    chk("in sticky held", 1'b1, st.sticky[1]);
    drive_fail(2'h0);
    step(12);
    chk("in now", 1'b1, st.now[1]);
    chk("no revert", 1'b0, sel);
    pulse_crs();
    chk("ref sticky clr", 1'b1, rstk);
  endtask : t_auto_switch
  task t_early;
    @(posedge i_clk) start <= 8'h14;
    drive_fail(2'h1);
    wait_lvl(0, 1'b0, 8);
    drive_fail(2'h0);
    wait_lvl(0, 1'b1, 30);
    chk("sel same", 1'b0, sel);
    @(posedge i_clk) start <= 8'h03;
  endtask : t_early
  task t_none;
    drive_fail(2'h3);
    wait_lvl(0, 1'b0, 8);
    step(60);
    chk("stay hold", 1'b0, hn);
    chk("sel none", 1'b0, sel);
    pulse_crs();
    chk("ref sticky refused", 1'b0, rstk);
    drive_fail(2'h0);
    wait_lvl(0, 1'b1, 100);
    chk("ref back", 1'b1, rnow);
    pulse_crs();
  endtask : t_none
  task t_short;
    @(posedge i_clk) mode <= 2'h2;
    src <= 1'b0;
    step(4);
    wait_lvl(0, 1'b1, 60);
    drive_fail(2'h1);
    wait_lvl(0, 1'b0, 6);
    chk("sel pin", 1'b0, sel);
    step(40);
    chk("short stay", 1'b0, hn);
    drive_fail(2'h0);
    wait_lvl(0, 1'b1, 30);
    chk("sel relock", 1'b0, sel);
  endtask : t_short
  task t_revert;
    @(posedge i_clk) mode <= 2'h3;
    revertive_enable <= 1'b1;
    prio <= 1'b1;
    step(3);
    chk("revert sel", 1'b1, sel);
    chk("revert no hold", 1'b1, hn);
  endtask : t_revert
  initial begin
    t_reset();
    t_manual();
    t_auto_switch();
    t_early();
    t_none();
    t_short();
    t_revert();
    print_verdict();
  end
endmodule : tb

// ==== verilog/rsh_params.svh ====
`ifndef RSH_PARAMS_SVH
`define RSH_PARAMS_SVH
// Switch mode codes, holdover_enable_n = 1
`define RSH_MODE_SHORT_HOLD 2'h2
`define RSH_MODE_AUTO_HOLD 2'h3
// Reset values
`define RSH_CNT_RST 8'h00
`define RSH_DIV_RST 18'h00000
`define RSH_VAL_RST 8'h00
`endif

// ==== verilog/rsh_pkg.sv ====
package rsh_pkg;
  // Controller states
  typedef enum logic [1:0] {
    RSH_LOCKED = 2'b00,
    RSH_HOLD_WAIT = 2'b01,
    RSH_HOLD_STAY = 2'b10
  } rsh_state_t;
  // Per-input monitor status
  typedef struct packed {
    logic [1:0] now;
    logic [1:0] sticky;
  } rsh_input_stat_t;
endpackage : rsh_pkg

// ==== verilog/rsh_ref_select.sv ====
`timescale 1ns/100ps
`include "rsh_params.svh"
//
// Overview of operation
// [R1] Short-term holdover: selection comes from pin or bit, never from the machine.
// [R2] Short-term holdover: loss on selected input enters holdover at once.
// [R3] Short-term holdover: revalidation count governs recovery, relock to same input.
// [R4] Auto-with-holdover: loss on primary or manual change enters holdover, starts counter.
// [R5] Auto-with-holdover: switch to valid secondary only after hold-off expiry.
// [R6] Auto-with-holdover: holdover ends early on primary revalidation or manual selection change.
// [R7] Auto-with-holdover: invalid secondary keeps the device in holdover.
// [R8] Holdover output comes from stored digital frequency and phase value.
// [R9] Reset leaves manual holdover control; selection from pin or bit.
// [R10] Manual holdover: selection change holds over until counter expiry, then switches.
// [R11] Manual holdover: status shows new selection, holdover flag low throughout.
// [R12] Auto loss on active input drops reference flags and starts countdown together.
// [R13] During countdown both inputs are monitored, losses flagged momentary and sticky.
// [R14] Active input recovering mid-countdown: status high, no switch, revertive ignored.
// [R15] Expiry with active revalidated: keep it, reference ok, leave holdover.
// [R16] Expiry with other input valid: select it, reference ok, leave holdover.
// [R17] Expiry with none valid: keep selection, reference low, sticky uncleared, stay.
// [R18] Revertive switching resumes after holdover only when enabled.
// [R19] Auto mode selection follows loss status; status shows machine choice.
// [R20] Hold-off counter ticks on divided clock and reloads after expiry.
// [R21] Revertive switch only to higher-priority revalidated input; off by default.
// [R22] Sticky flags set on event, cleared by write one when allowed.
//
module rsh_ref_select #(
  parameter int DIV_W = 18, // Hold-off divider width
  parameter int CNT_W = 8   // Hold-off counter width
) (
  input wire logic i_clk,                       // Divided VCXO clock
  input wire logic i_srst,                      // Sync reset, high
  input wire logic i_holdover_enable_n,         // 0 = manual holdover control
  input wire logic [1:0] i_switch_mode_code,    // Switch mode
  input wire logic i_source_internal,           // 1 = use internal select bit
  input wire logic i_select_pin,                // External select pin
  input wire logic i_select_bit,                // Internal select bit
  input wire logic [1:0] i_signal_loss,         // Per-input loss, from pins
  input wire logic [CNT_W-1:0] i_holdoff_start_value, // Counter start value
  input wire logic [DIV_W-1:0] i_holdoff_clock_divider, // Clock cycles per count, minus one
  input wire logic [7:0] i_revalidation_count,  // Clean cycles to revalidate, minus one
  input wire logic i_revertive_enable,          // Revertive switching
  input wire logic i_priority_high_in1,         // 1 = input 1 outranks input 0
  input wire logic [1:0] i_clear_input_sticky,  // Write-1 clear pulses
  input wire logic i_clear_reference_sticky,    // Write-1 clear pulse
  output rsh_pkg::rsh_input_stat_t o_input_stat, // Input status now/sticky
  output logic o_holdover_active_n,             // Low while in holdover
  output logic o_selected_input_status,         // Current input
  output logic o_reference_status_now,          // Selected reference ok
  output logic o_reference_status_sticky,       // Sticky reference ok, low on loss
  output logic o_use_stored_value               // PLL runs from stored value
);

  //--------------------------------------------------
  // Input synchronisers and validation
  //--------------------------------------------------
  logic [1:0] loss_meta_r;
  logic [1:0] loss_sync_r;
  logic [1:0] loss_prev_r;
  logic [1:0] valid_r;
  logic [7:0] val_cnt_r [2];
  logic pin_meta_r;
  logic pin_sync_r;

  // Two-stage sync of pins
  always_ff @(posedge i_clk) begin
    loss_meta_r <= i_signal_loss;
    loss_sync_r <= loss_meta_r;
    pin_meta_r <= i_select_pin;
    pin_sync_r <= pin_meta_r;
  end

  // Validation: input valid after revalidation_count + 1 clean cycles
  for (genvar g = 0; g < 2; g++) begin : g_val
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        val_cnt_r[g] <= `RSH_VAL_RST;
        valid_r[g] <= 1'b0;
        loss_prev_r[g] <= 1'b0;
      end else begin
        loss_prev_r[g] <= loss_sync_r[g];
        if (loss_sync_r[g]) begin
          val_cnt_r[g] <= `RSH_VAL_RST;
          valid_r[g] <= 1'b0;
        end else if (val_cnt_r[g] >= i_revalidation_count) begin // [R3]
          valid_r[g] <= 1'b1;
        end else begin
          val_cnt_r[g] <= val_cnt_r[g] + 8'h01;
        end
      end
    end
  end

  //--------------------------------------------------
  // Input sticky flags
  //--------------------------------------------------
  logic [1:0] in_sticky_r;
  logic [1:0] loss_rise;
  assign loss_rise = loss_sync_r & ~loss_prev_r;

  // Set wins over clear; monitored in every state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      in_sticky_r <= 2'h0;
    end else begin
      in_sticky_r <= (in_sticky_r & ~(i_clear_input_sticky & valid_r)) | loss_rise; // [R13] [R14] [R22]
    end
  end
  assign o_input_stat.now = valid_r;
  assign o_input_stat.sticky = in_sticky_r;

  //--------------------------------------------------
  // Mode decode and user selection
  //--------------------------------------------------
  logic mode_short;
  logic mode_auto;
  logic user_sel;
  logic user_sel_prev_r;
  logic user_change;
  assign mode_short = i_holdover_enable_n && (i_switch_mode_code == `RSH_MODE_SHORT_HOLD);
  assign mode_auto = i_holdover_enable_n && (i_switch_mode_code == `RSH_MODE_AUTO_HOLD);
  assign user_sel = i_source_internal ? i_select_bit : pin_sync_r; // [R1] [R9]

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      user_sel_prev_r <= 1'b0;
    end else begin
      user_sel_prev_r <= user_sel;
    end
  end
  assign user_change = user_sel != user_sel_prev_r;

  //--------------------------------------------------
  // Hold-off divider and down-counter
  //--------------------------------------------------
  logic [DIV_W-1:0] div_r;
  logic [CNT_W-1:0] cnt_r;
  logic counting;
  logic tick;
  logic expire;
  rsh_pkg::rsh_state_t state_r;

  assign counting = (state_r == rsh_pkg::RSH_HOLD_WAIT);
  assign tick = counting && (div_r == '0);
  assign expire = counting && (cnt_r == '0);

  // Clocked only while counting, reloads on start and expiry
  always_ff @(posedge i_clk) begin
    if (i_srst || !counting) begin
      div_r <= `RSH_DIV_RST;
      cnt_r <= i_srst ? `RSH_CNT_RST : i_holdoff_start_value; // [R20]
    end else if (expire) begin
      cnt_r <= i_holdoff_start_value; // [R20]
    end else begin
      div_r <= tick ? i_holdoff_clock_divider : div_r - 1'b1; // [R5] [R20]
      if (tick) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  //--------------------------------------------------
  // Selection state machine
  //--------------------------------------------------
  logic sel_r;
  logic act_valid;
  logic oth_valid;
  assign act_valid = valid_r[sel_r];
  assign oth_valid = valid_r[~sel_r];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= rsh_pkg::RSH_LOCKED; // [R9]
      sel_r <= 1'b0;
    end else begin
      unique case (state_r)
        rsh_pkg::RSH_LOCKED: begin
          if (mode_short) begin
            sel_r <= user_sel; // [R1]
            if (!valid_r[user_sel]) begin
              state_r <= rsh_pkg::RSH_HOLD_STAY; // [R2]
            end
          end else if (!i_holdover_enable_n && user_change) begin
            state_r <= rsh_pkg::RSH_HOLD_WAIT; // [R10]
          end else if (mode_auto && (!act_valid || user_change)) begin
            state_r <= rsh_pkg::RSH_HOLD_WAIT; // [R4] [R12]
          end else if (mode_auto && i_revertive_enable && oth_valid
                       && (i_priority_high_in1 != sel_r)) begin
            sel_r <= ~sel_r; // [R18] [R21]
          end
        end
        rsh_pkg::RSH_HOLD_WAIT: begin
          if (!i_holdover_enable_n) begin
            if (expire) begin
              sel_r <= user_sel; // [R10]
              state_r <= rsh_pkg::RSH_LOCKED;
            end
          end else if (mode_auto && user_change) begin
            sel_r <= user_sel; // [R6]
            state_r <= rsh_pkg::RSH_LOCKED;
          end else if (mode_auto && act_valid) begin
            // Active input came back mid-countdown: keep it and end holdover early
            state_r <= rsh_pkg::RSH_LOCKED; // [R6] [R14]
          end else if (expire) begin
            if (act_valid) begin
              state_r <= rsh_pkg::RSH_LOCKED; // [R15]
            end else if (oth_valid) begin
              sel_r <= ~sel_r; // [R5] [R16] [R19]
              state_r <= rsh_pkg::RSH_LOCKED;
            end else begin
              state_r <= rsh_pkg::RSH_HOLD_STAY; // [R7] [R17]
            end
          end
        end
        rsh_pkg::RSH_HOLD_STAY: begin
          if (mode_short) begin
            sel_r <= user_sel; // [R1]
            if (valid_r[user_sel]) begin
              state_r <= rsh_pkg::RSH_LOCKED; // [R3]
            end
          end else if (act_valid) begin
            state_r <= rsh_pkg::RSH_LOCKED; // [R6] [R15]
          end else if (oth_valid || user_change || !mode_auto) begin
            if (oth_valid) begin
              sel_r <= ~sel_r; // [R16]
            end
            state_r <= rsh_pkg::RSH_LOCKED;
          end
        end
        default: state_r <= rsh_pkg::RSH_LOCKED;
      endcase
    end
  end

  //--------------------------------------------------
  // Status outputs
  //--------------------------------------------------
  logic ref_sticky_r;
  logic in_hold;
  assign in_hold = (state_r != rsh_pkg::RSH_LOCKED);

  // Sticky reference: dropped on loss, clearable only when valid
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_sticky_r <= 1'b1;
    end else if (!act_valid && !in_hold) begin
      ref_sticky_r <= 1'b0; // [R12]
    end else if (i_clear_reference_sticky && act_valid && !in_hold) begin
      ref_sticky_r <= 1'b1; // [R15] [R16] [R17] [R22]
    end
  end

  assign o_holdover_active_n = !in_hold; // [R11]
  assign o_use_stored_value = in_hold; // [R8]
  assign o_selected_input_status = (!i_holdover_enable_n && in_hold) ? user_sel : sel_r; // [R11] [R19]
  assign o_reference_status_now = act_valid && !in_hold; // [R12] [R14] [R15]
  assign o_reference_status_sticky = ref_sticky_r;

  //--------------------------------------------------
  // Checks
  //--------------------------------------------------
  sequence s_auto_loss;
    mode_auto && state_r == rsh_pkg::RSH_LOCKED && !act_valid;
  endsequence

  auto_loss_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R4]
    s_auto_loss |=> !o_holdover_active_n) else $error("auto loss did not hold");
  hold_flag_pair_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R8]
    o_use_stored_value == !o_holdover_active_n) else $error("holdover flags disagree");
  ref_low_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R12]
    !o_holdover_active_n |-> !o_reference_status_now) else $error("ref high in hold");
  short_sel_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R1]
    mode_short && $stable(user_sel) |=> sel_r == $past(user_sel)) else $error("short sel");
  none_valid_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R17]
    mode_auto && expire && valid_r == 2'h0 |=> state_r == rsh_pkg::RSH_HOLD_STAY)
    else $error("no valid input left holdover");
  keep_sel_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R14]
    mode_auto && counting && !expire && !user_change |=> $stable(sel_r))
    else $error("switched during countdown");
  other_sw_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R16]
    mode_auto && expire && !act_valid && oth_valid && !user_change
    |=> sel_r != $past(sel_r) ##0 o_holdover_active_n) else $error("no failover");
  in_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R22]
    loss_rise[0] |=> in_sticky_r[0]) else $error("sticky missed loss");

  //--------------------------------------------------
  // Holdover entry/exit, sticky and revertive checks
  //--------------------------------------------------
  // Early exit when the active input revalidates in auto mode
  auto_reval_end_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R6]
    mode_auto && counting && act_valid |=> o_holdover_active_n)
    else $error("no early holdover exit");
  // Manual change enters holdover on the next edge
  manual_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    !i_holdover_enable_n && state_r == rsh_pkg::RSH_LOCKED && user_change
    |=> !o_holdover_active_n) else $error("manual change did not hold");
  // Reference sticky cannot be restored while holding over
  ref_clr_refused_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R17]
    in_hold && !ref_sticky_r |=> !ref_sticky_r) else $error("ref sticky cleared in hold");
  // Loss on input 1 is latched as well
  in1_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R13]
    loss_rise[1] |=> in_sticky_r[1]) else $error("sticky 1 missed loss");
  // Short-term mode holds over at once, no counter involved
  short_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R2]
    mode_short && state_r == rsh_pkg::RSH_LOCKED && !valid_r[user_sel]
    |=> state_r == rsh_pkg::RSH_HOLD_STAY) else $error("short loss did not hold");
  // Without revertive switching a locked auto selection stays put
  no_revert_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R21]
    mode_auto && state_r == rsh_pkg::RSH_LOCKED && !i_revertive_enable && act_valid
    && !user_change |=> $stable(sel_r)) else $error("switched without revertive");

endmodule : rsh_ref_select
